// ### core/sbwm_pkg.sv
// Constants shared by the burst SRAM write masking core.
// Assumes a single core clock that oversamples every pin of the memory interface.
package sbwm_pkg;
  localparam int unsigned DATA_W = 36;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned LANES = 4;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned WORDS = 32;
  // Width straps on the configuration pins.
  localparam logic [1:0] CFG_X9 = 2'h0;
  localparam logic [1:0] CFG_X18 = 2'h1;
  localparam logic [1:0] CFG_X36 = 2'h2;
  // Reset values.
  localparam logic RST_PEND = 1'h0;
  localparam logic RST_OE = 1'h0;
  localparam logic [35:0] RST_Q = 36'h0;
  localparam logic [3:0] SEL_NONE = 4'hf;
  typedef enum logic [2:0] {
    SBWM_RD_IDLE,
    SBWM_RD_WAIT_T1,
    SBWM_RD_WAIT_NEG,
    SBWM_RD_WAIT_POS,
    SBWM_RD_HOLD
  } sbwm_rd_e;
endpackage

// ### core/sbwm_core.sv
// Burst SRAM core with a masked double-word write port and a two-word read port.
// Assumes every pin is asynchronous to core_clk_i and much slower than it.
// Summary of operation
// - In x18 mode both lane selects low write all 18 bits of the word.
// - In x18 mode select 0 low, select 1 high writes bits 8:0 and keeps bits 17:9.
// - In x18 mode select 0 high, select 1 low writes bits 17:9 and keeps bits 8:0.
// - In x18 mode both selects high leave that half of the burst unwritten.
// - Each word and its selects are captured apart, first on the positive, second on the negative strobe rise.
// - In x9 mode the single select low writes bits 8:0 and high writes nothing.
// - In x36 mode all four selects low write all 36 bits.
// - In x36 mode selects 0 to 3 gate lanes 8:0, 17:9, 26:18 and 35:27 in that order.
// - In x9 and x36 modes all selects high write nothing for that word.
// - The two words of one write may carry different selects, each applied to its own word.
// - After power-up both ports are deselected and the read data is not driven.
// - The first word goes to location A+0 and the second to A+1.
// - Read data is launched on the output reference rises, or on the input strobes in single-strobe mode.
// - A read started in cycle t drives A+0 at the negative reference rise of t+1 and A+1 at the positive rise of t+2.
`timescale 1ns/1ps
module sbwm_core (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic strobe_p_i,
  input wire logic strobe_n_i,
  input wire logic out_ref_p_i,
  input wire logic out_ref_n_i,
  input wire logic single_strobe_mode_i,
  input wire logic [1:0] width_cfg_i,
  input wire logic write_port_select_n_i,
  input wire logic read_port_select_n_i,
  input wire logic [sbwm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sbwm_pkg::DATA_W-1:0] wdata_i,
  input wire logic [sbwm_pkg::LANES-1:0] byte_lane_write_select_n_i,
  output logic [sbwm_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_oe_o,
  output logic write_pending_o
);
  typedef struct packed {
    logic [2:0] kp;
    logic [2:0] kn;
    logic [2:0] cp;
    logic [2:0] cn;
    logic [1:0] single;
    logic [1:0] wps_n;
    logic [1:0] rps_n;
    logic [1:0][1:0] cfg;
    logic [1:0][sbwm_pkg::ADDR_W-1:0] addr;
    logic [1:0][sbwm_pkg::DATA_W-1:0] din;
    logic [1:0][sbwm_pkg::LANES-1:0] sel_n;
    logic wr_pend;
    logic [sbwm_pkg::ADDR_W-1:0] wa;
    logic [sbwm_pkg::DATA_W-1:0] word0;
    logic [sbwm_pkg::LANES-1:0] en0;
    logic [sbwm_pkg::ADDR_W-1:0] ra;
    sbwm_pkg::sbwm_rd_e rd;
    logic [sbwm_pkg::DATA_W-1:0] q;
    logic q_oe;
    logic [sbwm_pkg::WORDS-1:0][sbwm_pkg::DATA_W-1:0] mem;
  } sbwm_state_s;

  sbwm_state_s st_r;
  sbwm_state_s st_nxt;
  logic kp_rise;
  logic kn_rise;
  logic pos_ref;
  logic neg_ref;
  logic commit;
  logic [sbwm_pkg::LANES-1:0] en_now;

  // Turns active-low lane selects into lane enables for the strapped width.
  // lanes per width
  function automatic logic [3:0] lane_en(input logic [1:0] cfg, input logic [3:0] sel_n);
    logic [3:0] en;
    en = ~sel_n;
    case (cfg)
      sbwm_pkg::CFG_X9: lane_en = {3'h0, en[0]};
      sbwm_pkg::CFG_X18: lane_en = {2'h0, en[1:0]};
      default: lane_en = en;
    endcase
  endfunction

  // Keeps every disabled lane at its stored value.
  // deselected lanes kept
  function automatic logic [35:0] merge(input logic [35:0] old_w, input logic [35:0] new_w,
                                        input logic [3:0] en);
    logic [35:0] res;
    res = old_w;
    for (int i = 0; i < sbwm_pkg::LANES; i++)
    begin
      if (en[i])
      begin
        res[i*sbwm_pkg::LANE_W +: sbwm_pkg::LANE_W] = new_w[i*sbwm_pkg::LANE_W +: sbwm_pkg::LANE_W];
      end
    end
    merge = res;
  endfunction

  assign kp_rise = st_r.kp[1] & ~st_r.kp[2];
  assign kn_rise = st_r.kn[1] & ~st_r.kn[2];
  assign pos_ref = st_r.single[1] ? kp_rise : (st_r.cp[1] & ~st_r.cp[2]);
  assign neg_ref = st_r.single[1] ? kn_rise : (st_r.cn[1] & ~st_r.cn[2]);
  assign commit = kn_rise & st_r.wr_pend;
  assign en_now = lane_en(st_r.cfg[1], st_r.sel_n[1]);

  always_comb
  begin
    st_nxt = st_r;
    // Every pin but sys_rst_i goes through two flops; the third stage only feeds edge detection.
    st_nxt.kp = {st_r.kp[1:0], strobe_p_i};
    st_nxt.kn = {st_r.kn[1:0], strobe_n_i};
    st_nxt.cp = {st_r.cp[1:0], out_ref_p_i};
    st_nxt.cn = {st_r.cn[1:0], out_ref_n_i};
    st_nxt.single = {st_r.single[0], single_strobe_mode_i};
    st_nxt.wps_n = {st_r.wps_n[0], write_port_select_n_i};
    st_nxt.rps_n = {st_r.rps_n[0], read_port_select_n_i};
    st_nxt.cfg = {st_r.cfg[0], width_cfg_i};
    st_nxt.addr = {st_r.addr[0], addr_i};
    st_nxt.din = {st_r.din[0], wdata_i};
    st_nxt.sel_n = {st_r.sel_n[0], byte_lane_write_select_n_i};

    if (kp_rise && !st_r.wps_n[1])
    begin
      st_nxt.wr_pend = 1'b1;
      st_nxt.wa = st_r.addr[1];
      st_nxt.word0 = st_r.din[1];
      st_nxt.en0 = en_now;
    end
    if (commit)
    begin
      st_nxt.wr_pend = 1'b0;
      st_nxt.mem[{st_r.wa, 1'b0}] = merge(st_r.mem[{st_r.wa, 1'b0}], st_r.word0, st_r.en0);
      // second word uses its own selects
      st_nxt.mem[{st_r.wa, 1'b1}] = merge(st_r.mem[{st_r.wa, 1'b1}], st_r.din[1], en_now);
    end

    case (st_r.rd)
      sbwm_pkg::SBWM_RD_WAIT_T1:
      begin
        if (kp_rise)
        begin
          st_nxt.rd = sbwm_pkg::SBWM_RD_WAIT_NEG;
        end
      end
      sbwm_pkg::SBWM_RD_WAIT_NEG:
      begin
        if (neg_ref)
        begin
          st_nxt.q = st_r.mem[{st_r.ra, 1'b0}];
          st_nxt.q_oe = 1'b1;
          st_nxt.rd = sbwm_pkg::SBWM_RD_WAIT_POS;
        end
      end
      sbwm_pkg::SBWM_RD_WAIT_POS:
      begin
        if (pos_ref)
        begin
          st_nxt.q = st_r.mem[{st_r.ra, 1'b1}];
          st_nxt.rd = sbwm_pkg::SBWM_RD_HOLD;
        end
      end
      sbwm_pkg::SBWM_RD_HOLD:
      begin
        // The bus is released at the next reference rise so another device can follow.
        if (pos_ref || neg_ref)
        begin
          st_nxt.q_oe = 1'b0;
          st_nxt.rd = sbwm_pkg::SBWM_RD_IDLE;
        end
      end
      default:
      begin
        st_nxt.rd = sbwm_pkg::SBWM_RD_IDLE;
      end
    endcase
    // Reads requested while a burst is still in flight are dropped, a known limitation.
    if (kp_rise && !st_r.rps_n[1] &&
        (st_r.rd == sbwm_pkg::SBWM_RD_IDLE || st_r.rd == sbwm_pkg::SBWM_RD_HOLD))
    begin
      st_nxt.ra = st_r.addr[1];
      st_nxt.rd = sbwm_pkg::SBWM_RD_WAIT_T1;
    end

    // deselected after power-up
    // The edge chains keep following their pins through reset, so a reference parked high
    // is not mistaken for a rise once reset ends.
    if (sys_rst_i)
    begin
      st_nxt.wps_n = 2'h3;
      st_nxt.rps_n = 2'h3;
      st_nxt.sel_n = {sbwm_pkg::SEL_NONE, sbwm_pkg::SEL_NONE};
      st_nxt.wr_pend = sbwm_pkg::RST_PEND;
      st_nxt.rd = sbwm_pkg::SBWM_RD_IDLE;
      st_nxt.q = sbwm_pkg::RST_Q;
      st_nxt.q_oe = sbwm_pkg::RST_OE;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    st_r <= st_nxt;
  end

  assign rdata_o = st_r.q;
  assign rdata_oe_o = st_r.q_oe;
  assign write_pending_o = st_r.wr_pend;

  a_reset_deselect: assert property (@(posedge core_clk_i)
    sys_rst_i |=> !rdata_oe_o && !write_pending_o && rdata_o == sbwm_pkg::RST_Q)
    else $error("port not deselected after reset");

  a_x18_full_word: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X18 && st_r.en0 == 4'h3
    |=> st_r.mem[{st_r.wa, 1'b0}][17:0] == $past(st_r.word0[17:0]))
    else $error("x18 full word not written");

  a_x18_low_lane: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X18 && st_r.sel_n[1][1:0] == 2'h2
    |=> st_r.mem[{st_r.wa, 1'b1}][17:9] == $past(st_r.mem[{st_r.wa, 1'b1}][17:9]))
    else $error("x18 upper lane altered");

  a_x18_high_lane: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X18 && st_r.sel_n[1][1:0] == 2'h1
    |=> st_r.mem[{st_r.wa, 1'b1}][8:0] == $past(st_r.mem[{st_r.wa, 1'b1}][8:0]))
    else $error("x18 lower lane altered");

  a_x18_no_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X18 && st_r.sel_n[1][1:0] == 2'h3
    |=> $stable(st_r.mem[{st_r.wa, 1'b1}]))
    else $error("x18 deselected word written");

  a_x9_lane_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X9 && !st_r.sel_n[1][0]
    |=> st_r.mem[{st_r.wa, 1'b1}][8:0] == $past(st_r.din[1][8:0]))
    else $error("x9 word not written");

  a_x36_full_word: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X36 && st_r.sel_n[1] == 4'h0
    |=> st_r.mem[{st_r.wa, 1'b1}] == $past(st_r.din[1]))
    else $error("x36 full word not written");

  a_x36_lane_keep: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    commit && st_r.cfg[1] == sbwm_pkg::CFG_X36 && st_r.sel_n[1] == 4'hb
    |=> st_r.mem[{st_r.wa, 1'b1}][26:18] == $past(st_r.din[1][26:18]) &&
        st_r.mem[{st_r.wa, 1'b1}][35:27] == $past(st_r.mem[{st_r.wa, 1'b1}][35:27]))
    else $error("x36 lane order wrong");

  a_first_capture: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    kp_rise && !st_r.wps_n[1] |=> write_pending_o && st_r.en0 == $past(en_now))
    else $error("first word not captured");

  a_read_launch: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    st_r.rd == sbwm_pkg::SBWM_RD_WAIT_NEG && neg_ref
    |=> rdata_oe_o && rdata_o == $past(st_r.mem[{st_r.ra, 1'b0}]))
    else $error("first read word not launched");
endmodule

// ### verif/sbwm_ctrl_model.sv
// Memory controller model that drives the strobe pins, requests and write data.
// Assumes the core clock oversamples the pins; all changes happen on its falling edge.
`timescale 1ns/1ps
module sbwm_ctrl_model (
  input wire logic core_clk_i,
  output logic strobe_p_o,
  output logic strobe_n_o,
  output logic out_ref_p_o,
  output logic out_ref_n_o,
  output logic wps_n_o,
  output logic rps_n_o,
  output logic [3:0] addr_o,
  output logic [35:0] wdata_o,
  output logic [3:0] sel_n_o
);
  // Strobes park low together and references park high.
  initial
  begin
    strobe_p_o = 1'h0;
    strobe_n_o = 1'h0;
    out_ref_p_o = 1'h1;
    out_ref_n_o = 1'h1;
    wps_n_o = 1'h1;
    rps_n_o = 1'h1;
    addr_o = 4'h0;
    wdata_o = 36'h0;
    sel_n_o = 4'hf;
  end

  task automatic step(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Requests and the first word are set up before the positive strobe rise.
  task automatic kp(input logic w, input logic r, input logic [3:0] a, input logic [35:0] d,
                    input logic [3:0] s);
    wps_n_o = w;
    rps_n_o = r;
    addr_o = a;
    wdata_o = d;
    sel_n_o = s;
    step(3);
    strobe_p_o = 1'h1;
    step(4);
    strobe_p_o = 1'h0;
    wps_n_o = 1'h1;
    rps_n_o = 1'h1;
    addr_o = ~a;
    wdata_o = ~d;
    sel_n_o = ~s;
    step(4);
  endtask

  // Second word carries its own lane selects.
  task automatic kn(input logic [35:0] d, input logic [3:0] s);
    wdata_o = d;
    sel_n_o = s;
    step(3);
    strobe_n_o = 1'h1;
    step(4);
    strobe_n_o = 1'h0;
    wdata_o = ~d;
    sel_n_o = ~s;
    step(4);
  endtask

  // Pulses the chosen reference low for four cycles; it rises when both references return high.
  task automatic ref_rise(input logic pos);
    if (pos)
      out_ref_p_o = 1'h0;
    else
      out_ref_n_o = 1'h0;
    step(4);
    out_ref_p_o = 1'h1;
    out_ref_n_o = 1'h1;
    step(6);
  endtask
endmodule

// ### verif/test_sbwm_core.sv
// Self-checking bench for the masked write port and the two-word read port.
// Assumes the controller model owns every memory pin except reset, the width strap and the single-strobe mode pin.
`timescale 1ns/1ps
module test_sbwm_core;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [1:0] width_cfg = sbwm_pkg::CFG_X36;
  logic single = 1'h0;
  logic sp, sn, rp, rn, wps_n, rps_n, oe, pend;
  logic [3:0] addr, sel_n;
  logic [35:0] wdata, rdata;
  logic [35:0] mem [32];
  int err_count = 0;
  int comparisons = 0;

  always #2.5 core_clk_i = ~core_clk_i;

  sbwm_ctrl_model sbwm_ctrl_model_inst (.core_clk_i(core_clk_i), .strobe_p_o(sp),
    .strobe_n_o(sn), .out_ref_p_o(rp), .out_ref_n_o(rn), .wps_n_o(wps_n), .rps_n_o(rps_n),
    .addr_o(addr), .wdata_o(wdata), .sel_n_o(sel_n));

  sbwm_core sbwm_core_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .strobe_p_i(sp),
    .strobe_n_i(sn), .out_ref_p_i(rp), .out_ref_n_i(rn), .single_strobe_mode_i(single),
    .width_cfg_i(width_cfg), .write_port_select_n_i(wps_n), .read_port_select_n_i(rps_n),
    .addr_i(addr), .wdata_i(wdata), .byte_lane_write_select_n_i(sel_n), .rdata_o(rdata),
    .rdata_oe_o(oe), .write_pending_o(pend));

  task automatic end_sim;
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                        input logic [3:0] s);
    logic [35:0] r;
    int n;
    r = old;
    n = (width_cfg == sbwm_pkg::CFG_X9) ? 1 : (width_cfg == sbwm_pkg::CFG_X18) ? 2 : 4;
    for (int i = 0; i < n; i++)
      if (!s[i]) r[i*9 +: 9] = d[i*9 +: 9];
    return r;
  endfunction

  task automatic do_reset(input logic [1:0] cfg);
    sys_rst_i = 1'h1;
    width_cfg = cfg;
    sbwm_ctrl_model_inst.step(12);
    sys_rst_i = 1'h0;
    sbwm_ctrl_model_inst.step(4);
    chk({34'h0, pend, oe}, 36'h0, "flags after reset");
    chk(rdata, 36'h0, "read data after reset");
  endtask

  task automatic wr(input logic [3:0] a, input logic [35:0] d0, input logic [3:0] s0,
                    input logic [35:0] d1, input logic [3:0] s1);
    sbwm_ctrl_model_inst.kp(1'h0, 1'h1, a, d0, s0);
    chk(36'(pend), 36'h1, "pending after first word");
    sbwm_ctrl_model_inst.kn(d1, s1);
    chk(36'(pend), 36'h0, "pending after commit");
    mem[{a, 1'h0}] = merge(mem[{a, 1'h0}], d0, s0);
    mem[{a, 1'h1}] = merge(mem[{a, 1'h1}], d1, s1);
  endtask

  task automatic rd(input logic [3:0] a);
    logic [35:0] m;
    m = (width_cfg == sbwm_pkg::CFG_X9) ? 36'h1ff :
        (width_cfg == sbwm_pkg::CFG_X18) ? 36'h3ffff : 36'hfffffffff;
    sbwm_ctrl_model_inst.kp(1'h1, 1'h0, a, 36'h0, 4'hf);
    sbwm_ctrl_model_inst.kp(1'h1, 1'h1, a, 36'h0, 4'hf);
    sbwm_ctrl_model_inst.ref_rise(1'h0);
    chk({35'h0, oe}, 36'h1, "read enable on");
    chk(rdata & m, mem[{a, 1'h0}] & m, "first read word");
    sbwm_ctrl_model_inst.ref_rise(1'h1);
    chk(rdata & m, mem[{a, 1'h1}] & m, "second read word");
    sbwm_ctrl_model_inst.ref_rise(1'h0);
    chk({35'h0, oe}, 36'h0, "read enable off");
  endtask

  task automatic test_x36;
    do_reset(sbwm_pkg::CFG_X36);
    wr(4'h3, 36'h123456789, 4'h0, 36'hfedcba987, 4'h0);
    rd(4'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h3, 36'h5a5a5a5a5 + 36'(i), ~(4'h1 << i), 36'ha5a5a5a5a, 4'hf);
      rd(4'h3);
    end
  endtask

  task automatic test_x18;
    do_reset(sbwm_pkg::CFG_X18);
    wr(4'h5, 36'h00003c3c3, 4'hc, 36'h000021212, 4'hc);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h5, 36'h0001a2b3 + 36'(i), 4'hc | 4'(i), 36'h0003c4d5 - 36'(i), 4'hf - 4'(i));
      rd(4'h5);
    end
  endtask

  task automatic test_x9;
    do_reset(sbwm_pkg::CFG_X9);
    wr(4'h5, 36'h000000155, 4'he, 36'h0000000aa, 4'hf);
    rd(4'h5);
    wr(4'h5, 36'h000000033, 4'hf, 36'h0000001cc, 4'he);
    rd(4'h5);
  endtask

  // Single-strobe launch, with the spare width code that behaves as the widest mode.
  task automatic test_single;
    single = 1'h1;
    do_reset(2'h3);
    wr(4'h9, 36'h0f0f0f0f0, 4'h0, 36'h3c3c3c3c3, 4'h0);
    sbwm_ctrl_model_inst.kp(1'h1, 1'h0, 4'h9, 36'h0, 4'hf);
    sbwm_ctrl_model_inst.kp(1'h1, 1'h1, 4'h9, 36'h0, 4'hf);
    sbwm_ctrl_model_inst.kn(36'h0, 4'hf);
    chk({35'h0, oe}, 36'h1, "single mode enable on");
    chk(rdata, mem[{4'h9, 1'h0}], "single mode first word");
    sbwm_ctrl_model_inst.kp(1'h1, 1'h1, 4'h9, 36'h0, 4'hf);
    chk(rdata, mem[{4'h9, 1'h1}], "single mode second word");
    sbwm_ctrl_model_inst.kn(36'h0, 4'hf);
    chk({35'h0, oe}, 36'h0, "single mode enable off");
  endtask

  initial
  begin
    repeat (5000) @(posedge core_clk_i);
    err_count++;
    end_sim();
  end

  initial
  begin
    test_x36();
    test_x18();
    test_x9();
    test_single();
    end_sim();
  end
endmodule
